// ==== logic/t1_tx_pkg.sv ====
// Constants and types for the T1 transmit system-side timing block
package t1_tx_pkg;
	// Frame layout: one framing bit, then 24 channels of 8 bits
	localparam int CHANNELS = 24;
	localparam int CHAN_BITS = 8;
	localparam int FRAME_BITS = 193;
	localparam logic [7:0] LAST_BIT_POS = 8'hC0;
	localparam logic [2:0] CHANNEL_LSB = 3'h7;
	localparam logic [10:0] LAST_CHAN_POS = 11'h0C0;
	// Backplane frame lengths in bit times per rate
	localparam logic [10:0] FRAME_LEN_1544 = 11'h0C1;
	localparam logic [10:0] FRAME_LEN_2048 = 11'h100;
	localparam logic [10:0] FRAME_LEN_4096 = 11'h200;
	localparam logic [10:0] FRAME_LEN_8192 = 11'h400;
	// Link demand clock, in kHz, and its half period in frames
	localparam int LINE_CLOCK_KHZ = 1544;
	localparam int LINK_KHZ_NORMAL = 4;
	localparam int LINK_KHZ_ZERO_BYTE_SLOT_INTERCHANGE = 2;
	localparam int LINK_HALF_BITS_NORMAL = LINE_CLOCK_KHZ / (2 * LINK_KHZ_NORMAL);
	localparam int LINK_HALF_BITS_ZERO_BYTE_SLOT_INTERCHANGE = LINE_CLOCK_KHZ / (2 * LINK_KHZ_ZERO_BYTE_SLOT_INTERCHANGE);
	localparam logic [1:0] LINK_HALF_FRAMES_NORMAL =
		2'(LINK_HALF_BITS_NORMAL / FRAME_BITS);
	localparam logic [1:0] LINK_HALF_FRAMES_ZERO_BYTE_SLOT_INTERCHANGE =
		2'(LINK_HALF_BITS_ZERO_BYTE_SLOT_INTERCHANGE / FRAME_BITS);
	// Reset values
	localparam logic [7:0] LINE_POS_RESET = 8'h00;
	localparam logic [10:0] BP_POS_RESET = 11'h000;
	// Backplane clock rates
	typedef enum logic [1:0] {
		RATE_1544 = 2'b00,
		RATE_2048 = 2'b01,
		RATE_4096 = 2'b10,
		RATE_8192 = 2'b11
	} rate_t;
	// Width of the word crossing into the line domain
	localparam int CROSS_BITS = CHANNELS + 6;
endpackage : t1_tx_pkg

// ==== logic/bit_sync.sv ====
// Two-flop level synchroniser, one per bit
`timescale 1ns/100ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					meta[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule : bit_sync

// ==== logic/t1_tx_timing.sv ====
// T1 transmit system-side timing: strobes, mask, link clock, sampling
`timescale 1ns/100ps
module t1_tx_timing (
	input wire logic clock,
	input wire logic reset,
	input wire logic transmit_line_clock,
	input wire logic transmit_backplane_clock,
	input wire logic transmit_serial_input,
	input wire logic link_data_input,
	input wire logic elastic_store_enable,
	input wire logic zero_byte_slot_interchange,
	input wire logic link_insert_enable,
	input wire logic interleave_enable,
	input wire t1_tx_pkg::rate_t backplane_rate,
	input wire logic [t1_tx_pkg::CHANNELS-1:0] channel_mask_select,
	output logic transmit_channel_strobe,
	output logic transmit_channel_mask,
	output logic link_demand_clock,
	output logic formatter_data,
	output logic link_data_sample,
	output logic link_data_valid
);
	import t1_tx_pkg::*;

	// Core domain: backplane clock sampled as a pin
	logic bpclk_meta;
	logic bpclk_s;
	logic bpclk_d;
	logic ser_meta;
	logic ser_s;
	logic bp_fall;
	logic [10:0] bp_len;
	logic [10:0] bp_pos_r;
	logic [10:0] bp_pos_nxt;
	logic [10:0] bp_off;
	logic bp_in_chan;
	logic bp_strobe_r;
	logic bp_mask_r;
	logic bp_data_r;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			bpclk_meta <= 1'b0;
			bpclk_s <= 1'b0;
			bpclk_d <= 1'b0;
			ser_meta <= 1'b0;
			ser_s <= 1'b0;
		end else begin
			bpclk_meta <= transmit_backplane_clock;
			bpclk_s <= bpclk_meta;
			bpclk_d <= bpclk_s;
			ser_meta <= transmit_serial_input;
			ser_s <= ser_meta;
		end
	end

	assign bp_fall = bpclk_d & ~bpclk_s;

	// Fast rates fall back to 2.048 without the interleaved bus
	always_comb begin
		case (backplane_rate)
		RATE_1544: bp_len = FRAME_LEN_1544;
		RATE_2048: bp_len = FRAME_LEN_2048;
		RATE_4096: bp_len = interleave_enable ? FRAME_LEN_4096 :
			FRAME_LEN_2048;
		RATE_8192: bp_len = interleave_enable ? FRAME_LEN_8192 :
			FRAME_LEN_2048;
		default: bp_len = FRAME_LEN_2048;
		endcase
	end

	assign bp_pos_nxt = (bp_pos_r >= bp_len - 11'h001) ? BP_POS_RESET :
		bp_pos_r + 11'h001;
	assign bp_off = bp_pos_nxt - 11'h001;
	assign bp_in_chan = (bp_pos_nxt != BP_POS_RESET) &&
		(bp_pos_nxt <= LAST_CHAN_POS);

	// Backplane bit counter runs only with the store enabled
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			bp_pos_r <= BP_POS_RESET;
		end else if (!elastic_store_enable) begin
			bp_pos_r <= BP_POS_RESET;
		end else if (bp_fall) begin
			bp_pos_r <= bp_pos_nxt;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			bp_strobe_r <= 1'b0;
			bp_mask_r <= 1'b0;
			bp_data_r <= 1'b0;
		end else if (!elastic_store_enable) begin
			bp_strobe_r <= 1'b0;
			bp_mask_r <= 1'b0;
		end else if (bp_fall) begin
			bp_strobe_r <= bp_in_chan &&
				(bp_off[2:0] == CHANNEL_LSB);
			bp_mask_r <= bp_in_chan &&
				channel_mask_select[bp_off[7:3]];
			bp_data_r <= ser_s;
		end
	end

	a_bp_rate_map: assert property (@(posedge clock) disable iff (reset)
		(backplane_rate[1] && !interleave_enable) |->
		bp_len == FRAME_LEN_2048)
		else $error("fast backplane rate used without interleave");
	a_bp_idle: assert property (@(posedge clock) disable iff (reset)
		!elastic_store_enable |=> bp_pos_r == BP_POS_RESET &&
		!bp_strobe_r)
		else $error("backplane logic active with store disabled");
	a_bp_strobe_pos: assert property (@(posedge clock) disable iff (reset)
		$rose(bp_strobe_r) |-> bp_pos_r[2:0] == 3'h0 &&
		bp_pos_r != BP_POS_RESET)
		else $error("backplane strobe off the channel LSB");

	// Line domain: runs on the falling edge of the line clock
	logic line_clk_n;
	logic line_rst_meta;
	logic line_rst_r;
	logic [CROSS_BITS-1:0] cross_d;
	logic [CROSS_BITS-1:0] cross_q;
	logic es_l;
	logic zb_l;
	logic lie_l;
	logic bp_strobe_l;
	logic bp_mask_l;
	logic bp_data_l;
	logic [CHANNELS-1:0] mask_l;
	logic [7:0] line_pos_r;
	logic [7:0] line_pos_nxt;
	logic [7:0] line_off;
	logic line_in_chan;
	logic [1:0] link_frames_r;
	logic [1:0] link_half;
	logic zb_hold_r;

	assign line_clk_n = ~transmit_line_clock;

	always_ff @(posedge line_clk_n or posedge reset) begin
		if (reset) begin
			line_rst_meta <= 1'b1;
			line_rst_r <= 1'b1;
		end else begin
			line_rst_meta <= 1'b0;
			line_rst_r <= line_rst_meta;
		end
	end

	assign cross_d = {elastic_store_enable, zero_byte_slot_interchange,
		link_insert_enable, bp_strobe_r, bp_mask_r, bp_data_r,
		channel_mask_select};

	bit_sync #(.WIDTH(CROSS_BITS)) u_cross (
		.clk(line_clk_n),
		.rst(line_rst_r),
		.d(cross_d),
		.q(cross_q)
	);

	assign {es_l, zb_l, lie_l, bp_strobe_l, bp_mask_l, bp_data_l,
		mask_l} = cross_q;

	assign line_pos_nxt = (line_pos_r == LAST_BIT_POS) ? LINE_POS_RESET :
		line_pos_r + 8'h01;
	assign line_off = line_pos_nxt - 8'h01;
	assign line_in_chan = line_pos_nxt != LINE_POS_RESET;

	always_ff @(posedge line_clk_n or posedge line_rst_r) begin
		if (line_rst_r) begin
			line_pos_r <= LINE_POS_RESET;
		end else begin
			line_pos_r <= line_pos_nxt;
		end
	end

	// Output timing source follows the elastic store setting
	always_ff @(posedge line_clk_n or posedge line_rst_r) begin
		if (line_rst_r) begin
			transmit_channel_strobe <= 1'b0;
			transmit_channel_mask <= 1'b0;
			formatter_data <= 1'b0;
		end else if (es_l) begin
			transmit_channel_strobe <= bp_strobe_l;
			transmit_channel_mask <= bp_mask_l;
			formatter_data <= bp_data_l;
		end else begin
			transmit_channel_strobe <= line_in_chan &&
				(line_off[2:0] == CHANNEL_LSB);
			transmit_channel_mask <= line_in_chan &&
				mask_l[line_off[7:3]];
			formatter_data <= transmit_serial_input;
		end
	end

	// Link demand clock toggles every one or two frames
	// Mode taken at each toggle, so a half period never mixes modes
	assign link_half = zb_hold_r ? LINK_HALF_FRAMES_ZERO_BYTE_SLOT_INTERCHANGE :
		LINK_HALF_FRAMES_NORMAL;

	always_ff @(posedge line_clk_n or posedge line_rst_r) begin
		if (line_rst_r) begin
			link_frames_r <= 2'h0;
			link_demand_clock <= 1'b0;
			zb_hold_r <= 1'b0;
		end else if (line_pos_r == LAST_BIT_POS) begin
			if (link_frames_r + 2'h1 >= link_half) begin
				link_frames_r <= 2'h0;
				link_demand_clock <= ~link_demand_clock;
				zb_hold_r <= zb_l;
			end else begin
				link_frames_r <= link_frames_r + 2'h1;
			end
		end
	end

	// Link bit taken in the framing bit time for insertion
	always_ff @(posedge line_clk_n or posedge line_rst_r) begin
		if (line_rst_r) begin
			link_data_sample <= 1'b0;
			link_data_valid <= 1'b0;
		end else begin
			link_data_valid <= lie_l && !line_in_chan;
			if (lie_l && !line_in_chan) begin
				link_data_sample <= link_data_input;
			end
		end
	end

	a_strobe_spacing: assert property (@(posedge line_clk_n)
		disable iff (line_rst_r || es_l)
		(!$past(es_l) && transmit_channel_strobe &&
		line_pos_r != LAST_BIT_POS) |=>
		!transmit_channel_strobe [*7] ##1 transmit_channel_strobe)
		else $error("channel strobe not every eight bits");
	a_framing_gap: assert property (@(posedge line_clk_n)
		disable iff (line_rst_r || es_l)
		(!$past(es_l) && transmit_channel_strobe &&
		line_pos_r == LAST_BIT_POS) |=>
		!transmit_channel_strobe [*8] ##1 transmit_channel_strobe)
		else $error("framing bit gap wrong");
	a_mask_value: assert property (@(posedge line_clk_n)
		disable iff (line_rst_r)
		(!es_l && $past(!es_l) && line_pos_r != LINE_POS_RESET) |->
		transmit_channel_mask == $past(mask_l[line_off[7:3]]))
		else $error("channel mask does not match select");
	a_serial_path: assert property (@(posedge line_clk_n)
		disable iff (line_rst_r)
		(!$past(line_rst_r) && $past(!es_l)) |->
		formatter_data == $past(transmit_serial_input))
		else $error("serial input not sampled on line edge");
	a_link_normal: assert property (@(posedge line_clk_n)
		disable iff (line_rst_r)
		($rose(link_demand_clock) && !zb_hold_r) |->
		##193 $fell(link_demand_clock))
		else $error("link clock half period not one frame");
	a_link_zero_byte_slot_interchange: assert property (@(posedge line_clk_n)
		disable iff (line_rst_r)
		($rose(link_demand_clock) && zb_hold_r) |->
		##[386:386] $fell(link_demand_clock))
		else $error("link clock half period not two frames");
	a_link_sample: assert property (@(posedge line_clk_n)
		disable iff (line_rst_r)
		link_data_valid |-> line_pos_r == LINE_POS_RESET &&
		link_data_sample == $past(link_data_input))
		else $error("link data not taken in framing bit");
endmodule : t1_tx_timing

// ==== test/backplane_model.sv ====
// Backplane-side model: serial data and system clock for the timing block
`timescale 1ns/100ps
module backplane_model (
	input wire logic line_clock,
	input wire logic store_on,
	input wire logic bit_in,
	input wire logic [9:0] half_ns,
	output logic backplane_clock,
	output logic serial_out
);
	logic line_bit_r = 1'b0;
	logic bp_bit_r = 1'b0;
	// Launched mid-bit, settled at the falling sample edge
	always @(posedge line_clock) begin
		line_bit_r <= bit_in;
	end
	// Clock at the chosen rate, held low while the store is off
	always begin
		if (!store_on) begin
			backplane_clock = 1'b0;
			@(posedge store_on);
		end
		#(half_ns) backplane_clock = 1'b1;
		bp_bit_r = bit_in;
		#(half_ns) backplane_clock = 1'b0;
	end
	assign serial_out = store_on ? bp_bit_r : line_bit_r;
endmodule : backplane_model

// ==== test/t1_tx_timing_tb.sv ====
// Self-checking bench for the transmit system-side timing block
`timescale 1ns/100ps
module t1_tx_timing_tb;
	import t1_tx_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic lc = 1'b0;
	logic bit_in = 1'b0;
	logic link_in = 1'b0;
	logic store = 1'b0;
	logic zb = 1'b0;
	logic ins = 1'b0;
	logic ilv = 1'b0;
	logic [9:0] half = 10'h144;
	rate_t rate = RATE_1544;
	logic [23:0] sel = 24'h000000;
	logic bpc, ser, strobe, mask, lclk, fdata, lsamp, lvalid;
	logic [31:0] seed = 32'h3DA6;
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	int sr = 0;
	int mr = 0;
	t1_tx_timing uut (
		.clock(clock), .reset(reset), .transmit_line_clock(lc),
		.transmit_backplane_clock(bpc), .transmit_serial_input(ser),
		.link_data_input(link_in), .elastic_store_enable(store),
		.zero_byte_slot_interchange(zb), .link_insert_enable(ins),
		.interleave_enable(ilv), .backplane_rate(rate),
		.channel_mask_select(sel), .transmit_channel_strobe(strobe),
		.transmit_channel_mask(mask), .link_demand_clock(lclk),
		.formatter_data(fdata), .link_data_sample(lsamp),
		.link_data_valid(lvalid)
	);
	backplane_model partner (
		.line_clock(lc), .store_on(store), .bit_in(bit_in),
		.half_ns(half), .backplane_clock(bpc), .serial_out(ser)
	);
	always #25 clock = ~clock;
	initial begin
		#3;
		forever #6 lc = ~lc;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Rising edges of the mask over one frame
	function automatic int mask_rises(input logic [23:0] s);
		int n = 0;
		for (int i = 0; i < 24; i++) begin
			if (s[i] && (i == 0 || !s[i - 1])) n++;
		end
		return n;
	endfunction : mask_rises
	task automatic close_out;
		if (err_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	always @(posedge lc) begin
		seed = lfsr(seed);
		bit_in <= seed[0];
		link_in <= seed[9];
	end
	always @(posedge strobe) sr++;
	always @(posedge mask) mr++;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			close_out;
		end
	end
	task automatic run_line(input logic z, input logic [23:0] s0);
		int p, tog;
		logic s, l, prev;
		@(posedge clock);
		#5;
		zb = z;
		ins = 1'b1;
		sel = s0;
		repeat (20) @(negedge lc);
		p = 0;
		while (lvalid !== 1'b1 && p < 500) begin
			@(negedge lc);
			#1;
			p++;
		end
		prev = lclk;
		tog = 0;
		for (int k = 1; k <= 772; k++) begin
			@(negedge lc);
			s = ser;
			l = link_in;
			#1;
			p = k % 193;
			check(strobe, p != 0 && p % 8 == 0);
			check(mask, p == 0 ? 1'b0 : sel[(p - 1) / 8]);
			check(fdata, s);
			check(lvalid, p == 0);
			if (p == 0) check(lsamp, l);
			if (lclk !== prev) tog++;
			prev = lclk;
		end
		check(tog, z ? 2 : 4);
	endtask : run_line
	task automatic run_bp(input rate_t r, input logic il, input int len,
		input logic [9:0] h);
		int c, m;
		@(posedge clock);
		#5;
		store = 1'b0;
		rate = r;
		ilv = il;
		half = h;
		seed = lfsr(seed);
		sel = seed[23:0];
		repeat (20) @(posedge clock);
		#5;
		store = 1'b1;
		repeat (40) @(negedge bpc);
		c = sr;
		m = mr;
		repeat (len) @(negedge bpc);
		check(sr - c, 24);
		check(mr - m, mask_rises(sel));
	endtask : run_bp
	initial begin
		int n;
		repeat (4) @(posedge clock);
		#5;
		reset = 1'b0;
		seed = lfsr(seed);
		run_line(1'b0, seed[23:0]);
		run_line(1'b1, 24'h800001);
		@(posedge clock);
		#5;
		ins = 1'b0;
		repeat (20) @(negedge lc);
		n = 0;
		repeat (400) begin
			@(negedge lc);
			#1;
			if (lvalid !== 1'b0) n++;
		end
		check(n, 0);
		run_bp(RATE_1544, 1'b0, 193, 10'h144);
		run_bp(RATE_2048, 1'b0, 256, 10'h0F4);
		run_bp(RATE_4096, 1'b1, 512, 10'h07A);
		run_bp(RATE_8192, 1'b0, 256, 10'h07A);
		run_bp(RATE_8192, 1'b1, 1024, 10'h07A);
		close_out;
	end
endmodule : t1_tx_timing_tb
